//--- rtl/rcr_defines.svh
// Offsets, field positions, reset values and counts of the regulator control bank.
`ifndef RCR_DEFINES_SVH
`define RCR_DEFINES_SVH

// ==========================================================================
// Register indices (byte address is four times the index).
// ==========================================================================
`define RCR_IDX_PRO_BUCK 8'h22
`define RCR_IDX_MEM_BUCK 8'h23
`define RCR_IDX_IO_BUCK 8'h24
`define RCR_IDX_PERI_BUCK 8'h25
`define RCR_IDX_RSVD_26 8'h26
`define RCR_IDX_RSVD_27 8'h27
`define RCR_IDX_LIN_THREE 8'h28
`define RCR_IDX_RSVD_29 8'h29
`define RCR_IDX_RSVD_2A 8'h2a
`define RCR_IDX_RSVD_2B 8'h2b
`define RCR_IDX_LIN_SEVEN 8'h2c
`define RCR_IDX_LIN_EIGHT 8'h2d
`define RCR_IDX_LIN_NINE 8'h2e
`define RCR_IDX_RSVD_2F 8'h2f
`define RCR_IDX_LIN_ELEVEN 8'h30
`define RCR_IDX_VIB 8'h31
`define RCR_IDX_VSEL_ONE 8'h32
`define RCR_IDX_VSEL_TWO 8'h33
`define RCR_IDX_SLOT_BASE 8'h40
`define RCR_NUM_SLOT_REGS 5

// ==========================================================================
// Field positions inside a control register.
// ==========================================================================
`define RCR_BIT_ON 0
`define RCR_FLD_ON_SRC 2:1
`define RCR_BIT_BUCK_TARGET 3
`define RCR_BIT_PULLDOWN_OFF 3
`define RCR_BIT_LIN_VCHOICE 4
`define RCR_BIT_PERI_SWITCH 4
`define RCR_FLD_V_SRC 6:5
`define RCR_BIT_LIN_TARGET 7
`define RCR_BIT_PERI_SW_TARGET 7
`define RCR_FLD_VIB 5:0

// Bits of the two ramped voltage-select registers.
`define RCR_VSEL_CORE_ONE 0
`define RCR_VSEL_CORE_TWO 1
`define RCR_VSEL_PRO 2
`define RCR_VSEL_MEM 3
`define RCR_VSEL_PERI 4
`define RCR_VSEL_LIN_THREE 7
`define RCR_VSEL2_IO 0

// ==========================================================================
// Implemented-bit masks; everything else reads zero.
// ==========================================================================
`define RCR_MASK_BUCK 8'h6f
`define RCR_MASK_PERI 8'hff
`define RCR_MASK_LIN_THREE 8'hef
`define RCR_MASK_LIN 8'hff
`define RCR_MASK_VIB 8'h3f
`define RCR_MASK_VSEL_ONE 8'h9f
`define RCR_MASK_VSEL_TWO 8'h01
`define RCR_MASK_SLOT 8'hff

// ==========================================================================
// Reset values and counts.
// ==========================================================================
`define RCR_RST_REG 8'h00
`define RCR_RST_SLOT 4'h0
`define RCR_RST_DATA 32'h0000_0000
`define RCR_VIB_STEPS 6'h3f

`endif

//--- rtl/rcr_pkg.sv
// Types shared by the regulator control bank.
package rcr_pkg;

	// ==================================================================
	// General pins that can drive enables and voltage choices.
	// ==================================================================
	typedef struct packed {
		logic thirteen; // General pin thirteen, high when active.
		logic two; // General pin two, high when active.
		logic one; // General pin one, high when active.
	} rcr_pins_t;

	// ==================================================================
	// Power sequencer slot announcement.
	// ==================================================================
	typedef struct packed {
		logic step; // One-cycle pulse when the sequencer reaches a slot.
		logic [3:0] slot; // The slot being reached.
	} rcr_seq_t;

endpackage : rcr_pkg

//--- rtl/rcr_bank.sv
// Regulator control register bank with APB slave, pin and sequencer control.
`timescale 1ns/1ps
`include "rcr_defines.svh"

// Function
// - Bit 0 switches each regulator off or on.
// - Bits 2:1 pick sequencer or pin enable.
// - Pin rise enables, pin fall disables regulator.
// - Bits 6:5 pin rise selects A, fall B.
// - Linear seven to eleven switch voltage immediately.
// - Buck bit 3 is sequencer enable target.
// - Linear bit 7 is sequencer enable target.
// - Memory buck target needs default supply.
// - Linear bit 3 disables off-state pull-down.
// - Linear seven to eleven bit 4 picks target A or B.
// - Select register 0x32 holds ramped A/B bits.
// - Peripheral switch bit 4, sequencer target bit 7.
// - Vibration zero brakes: low side on.
// - Nonzero vibration level gives linear average.
// - Four-bit sequencer slot per regulator.
module rcr_bank
	import rcr_pkg::*;
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pin and sequencer inputs.
	input wire rcr_pins_t pins,
	input wire rcr_seq_t seq,
	input wire logic memory_default_supply,
	// Regulator controls, index 0 processor buck to 8 linear eleven.
	output logic [8:0] regulator_on,
	output logic [8:0] voltage_second,
	output logic [1:0] core_voltage_second,
	output logic [4:0] pulldown_on,
	output logic peripheral_switch_closed,
	// Vibration motor bridge.
	output logic vib_high_side,
	output logic vib_low_side
);

	// ==================================================================
	// Register map tables.
	// ==================================================================
	// Control register index per regulator.
	localparam logic [7:0] CTRL_IDX [9] = '{`RCR_IDX_PRO_BUCK, `RCR_IDX_MEM_BUCK,
		`RCR_IDX_IO_BUCK, `RCR_IDX_PERI_BUCK, `RCR_IDX_LIN_THREE, `RCR_IDX_LIN_SEVEN,
		`RCR_IDX_LIN_EIGHT, `RCR_IDX_LIN_NINE, `RCR_IDX_LIN_ELEVEN};
	// Implemented bits per control register.
	localparam logic [7:0] CTRL_MASK [9] = '{`RCR_MASK_BUCK, `RCR_MASK_BUCK,
		`RCR_MASK_BUCK, `RCR_MASK_PERI, `RCR_MASK_LIN_THREE, `RCR_MASK_LIN,
		`RCR_MASK_LIN, `RCR_MASK_LIN, `RCR_MASK_LIN};

	// ==================================================================
	// Storage.
	// ==================================================================
	logic [7:0] ctrl_q [9]; // Control registers.
	logic [7:0] next_ctrl [9]; // Next control register values.
	logic [3:0] slot_q [9]; // Sequencer slot per regulator.
	logic [3:0] next_slot [9]; // Next slot values.
	logic [7:0] vsel_one_q; // Ramped voltage select bits.
	logic [7:0] next_vsel_one; // Next ramped select bits.
	logic [7:0] vsel_two_q; // Second ramped select register.
	logic [7:0] next_vsel_two; // Next second select register.
	logic [7:0] vib_q; // Vibration level register.
	logic [7:0] next_vib; // Next vibration level.
	rcr_pins_t pins_prev; // Pin levels one cycle ago.
	logic [5:0] pwm_cnt; // Vibration PWM phase, 0 to 62.
	logic [31:0] read_value; // Read data for the addressed register.

	// ==================================================================
	// APB decode.
	// ==================================================================
	wire [7:0] apb_idx = paddr[9:2]; // Register index from the byte address.
	wire aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00); // Word access in range.
	wire setup = psel && !penable; // Setup phase of a transfer.
	wire access = psel && penable && pready; // Completing access phase.
	wire hit_vib = aligned && (apb_idx == `RCR_IDX_VIB); // Vibration register.
	wire hit_vsel_one = aligned && (apb_idx == `RCR_IDX_VSEL_ONE); // First select register.
	wire hit_vsel_two = aligned && (apb_idx == `RCR_IDX_VSEL_TWO); // Second select register.
	// Reserved holes inside the bank answer without error.
	wire hit_rsvd = aligned && (apb_idx == `RCR_IDX_RSVD_26 || apb_idx == `RCR_IDX_RSVD_27
		|| apb_idx == `RCR_IDX_RSVD_29 || apb_idx == `RCR_IDX_RSVD_2A
		|| apb_idx == `RCR_IDX_RSVD_2B || apb_idx == `RCR_IDX_RSVD_2F);
	wire [7:0] slot_off = apb_idx - `RCR_IDX_SLOT_BASE; // Offset into the slot registers.
	wire hit_slot = aligned && (apb_idx >= `RCR_IDX_SLOT_BASE)
		&& (slot_off < 8'(`RCR_NUM_SLOT_REGS)); // Slot registers.
	logic [8:0] hit_ctrl; // One bit per control register.
	wire mapped = (|hit_ctrl) || hit_vib || hit_vsel_one || hit_vsel_two || hit_rsvd || hit_slot;
	wire wr_fire = access && pwrite && pstrb[0] && !pslverr; // Write takes effect now.

	// ==================================================================
	// Pin edges.
	// ==================================================================
	wire [2:0] pin_rise = pins & ~pins_prev; // Passive to active edges.
	wire [2:0] pin_fall = ~pins & pins_prev; // Active to passive edges.

	// Picks the edge of the pin that a two-bit source field names.
	function automatic logic pick(input logic [1:0] src, input logic [2:0] v);
		logic r;
		r = 1'b0;
		case (src)
			2'b01: r = v[0];
			2'b10: r = v[1];
			2'b11: r = v[2];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// ==================================================================
	// Per-regulator events.
	// ==================================================================
	logic [8:0] on_rise; // Chosen enable pin rose.
	logic [8:0] on_fall; // Chosen enable pin fell.
	logic [8:0] v_rise; // Chosen voltage pin rose.
	logic [8:0] v_fall; // Chosen voltage pin fell.
	logic [8:0] seq_hit; // Sequencer applies its target now.
	logic [8:0] seq_target; // Enable state the sequencer applies.

	genvar g;
	generate
		for (g = 0; g < 9; g++)
		begin : g_reg
			wire [1:0] on_src = ctrl_q[g][`RCR_FLD_ON_SRC]; // Enable source field.
			wire [1:0] v_src = ctrl_q[g][`RCR_FLD_V_SRC]; // Voltage source field.
			assign hit_ctrl[g] = aligned && (apb_idx == CTRL_IDX[g]);
			assign on_rise[g] = pick(on_src, pin_rise);
			assign on_fall[g] = pick(on_src, pin_fall);
			assign v_rise[g] = pick(v_src, pin_rise);
			assign v_fall[g] = pick(v_src, pin_fall);
			// The memory buck target only acts when it is a default supply.
			assign seq_hit[g] = (on_src == 2'b00) && seq.step && (seq.slot == slot_q[g])
				&& ((g != 1) || memory_default_supply);
			// Buck targets sit in bit 3, linear targets in bit 7.
			assign seq_target[g] = (g < 4) ? ctrl_q[g][`RCR_BIT_BUCK_TARGET]
				: ctrl_q[g][`RCR_BIT_LIN_TARGET];
		end
	endgenerate

	// ==================================================================
	// Read multiplexer; unimplemented bits and holes read zero.
	// ==================================================================
	always_comb
	begin
		read_value = `RCR_RST_DATA;
		for (int i = 0; i < 9; i++)
		begin
			if (hit_ctrl[i])
			begin
				read_value[7:0] = ctrl_q[i];
			end
		end
		if (hit_vib)
		begin
			read_value[7:0] = vib_q;
		end
		if (hit_vsel_one)
		begin
			read_value[7:0] = vsel_one_q;
		end
		if (hit_vsel_two)
		begin
			read_value[7:0] = vsel_two_q;
		end
		for (int k = 0; k < `RCR_NUM_SLOT_REGS; k++)
		begin
			if (hit_slot && slot_off[2:0] == 3'(k))
			begin
				read_value[3:0] = slot_q[2 * k];
				read_value[7:4] = (k < 4) ? slot_q[2 * k + 1] : `RCR_RST_SLOT;
			end
		end
	end

	// ==================================================================
	// Next state: software write first, hardware events override it.
	// ==================================================================
	always_comb
	begin
		next_ctrl = ctrl_q;
		next_slot = slot_q;
		next_vsel_one = vsel_one_q;
		next_vsel_two = vsel_two_q;
		next_vib = vib_q;
		// Software writes store only implemented bits.
		for (int i = 0; i < 9; i++)
		begin
			if (wr_fire && hit_ctrl[i])
			begin
				next_ctrl[i] = pwdata[7:0] & CTRL_MASK[i];
			end
		end
		if (wr_fire && hit_vib)
		begin
			next_vib = pwdata[7:0] & `RCR_MASK_VIB;
		end
		if (wr_fire && hit_vsel_one)
		begin
			next_vsel_one = pwdata[7:0] & `RCR_MASK_VSEL_ONE;
		end
		if (wr_fire && hit_vsel_two)
		begin
			next_vsel_two = pwdata[7:0] & `RCR_MASK_VSEL_TWO;
		end
		for (int k = 0; k < `RCR_NUM_SLOT_REGS; k++)
		begin
			if (wr_fire && hit_slot && slot_off[2:0] == 3'(k))
			begin
				next_slot[2 * k] = pwdata[3:0];
				if (k < 4)
				begin
					next_slot[2 * k + 1] = pwdata[7:4];
				end
			end
		end
		// Hardware events win over a write in the same cycle.
		for (int i = 0; i < 9; i++)
		begin
			if (seq_hit[i])
			begin
				next_ctrl[i][`RCR_BIT_ON] = seq_target[i];
			end
			if (on_rise[i])
			begin
				next_ctrl[i][`RCR_BIT_ON] = 1'b1;
			end
			else if (on_fall[i])
			begin
				next_ctrl[i][`RCR_BIT_ON] = 1'b0;
			end
			// A rising voltage pin picks target A, a falling one target B.
			if (v_rise[i] || v_fall[i])
			begin
				case (i)
					0: next_vsel_one[`RCR_VSEL_PRO] = v_fall[i];
					1: next_vsel_one[`RCR_VSEL_MEM] = v_fall[i];
					2: next_vsel_two[`RCR_VSEL2_IO] = v_fall[i];
					3: next_vsel_one[`RCR_VSEL_PERI] = v_fall[i];
					4: next_vsel_one[`RCR_VSEL_LIN_THREE] = v_fall[i];
					default: next_ctrl[i][`RCR_BIT_LIN_VCHOICE] = v_fall[i];
				endcase
			end
		end
		// The peripheral switch follows its target at the peripheral buck slot.
		if (seq_hit[3])
		begin
			next_ctrl[3][`RCR_BIT_PERI_SWITCH] = ctrl_q[3][`RCR_BIT_PERI_SW_TARGET];
		end
	end

	// ==================================================================
	// Register storage.
	// ==================================================================
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < 9; i++)
			begin
				ctrl_q[i] <= `RCR_RST_REG;
				slot_q[i] <= `RCR_RST_SLOT;
			end
			vsel_one_q <= `RCR_RST_REG;
			vsel_two_q <= `RCR_RST_REG;
			vib_q <= `RCR_RST_REG;
			pins_prev <= '0;
		end
		else
		begin
			ctrl_q <= next_ctrl;
			slot_q <= next_slot;
			vsel_one_q <= next_vsel_one;
			vsel_two_q <= next_vsel_two;
			vib_q <= next_vib;
			pins_prev <= pins;
		end
	end

	// ==================================================================
	// APB answer: ready one cycle after setup, data and error registered.
	// ==================================================================
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `RCR_RST_DATA;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup && !mapped;
			prdata <= (setup && !pwrite) ? read_value : `RCR_RST_DATA;
		end
	end

	// ==================================================================
	// Registered pull-down and vibration bridge outputs.
	// ==================================================================
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pulldown_on <= '0;
			pwm_cnt <= '0;
			vib_high_side <= 1'b0;
			vib_low_side <= 1'b0;
		end
		else
		begin
			for (int j = 0; j < 5; j++)
			begin
				pulldown_on[j] <= !next_ctrl[j + 4][`RCR_BIT_ON]
					&& !next_ctrl[j + 4][`RCR_BIT_PULLDOWN_OFF];
			end
			pwm_cnt <= (pwm_cnt == `RCR_VIB_STEPS - 6'h01) ? 6'h00 : pwm_cnt + 6'h01;
			// Duty is level out of 63, so the average rises linearly to full scale.
			vib_high_side <= (vib_q[`RCR_FLD_VIB] != 6'h00)
				&& (pwm_cnt < vib_q[`RCR_FLD_VIB]);
			// Level zero brakes: low side on, high side off.
			vib_low_side <= (vib_q[`RCR_FLD_VIB] == 6'h00)
				|| (pwm_cnt >= vib_q[`RCR_FLD_VIB]);
		end
	end

	// ==================================================================
	// Outputs taken straight from register bits.
	// ==================================================================
	generate
		for (g = 0; g < 9; g++)
		begin : g_on
			assign regulator_on[g] = ctrl_q[g][`RCR_BIT_ON];
		end
		for (g = 5; g < 9; g++)
		begin : g_lin_v
			assign voltage_second[g] = ctrl_q[g][`RCR_BIT_LIN_VCHOICE];
		end
	endgenerate
	assign voltage_second[0] = vsel_one_q[`RCR_VSEL_PRO];
	assign voltage_second[1] = vsel_one_q[`RCR_VSEL_MEM];
	assign voltage_second[2] = vsel_two_q[`RCR_VSEL2_IO];
	assign voltage_second[3] = vsel_one_q[`RCR_VSEL_PERI];
	assign voltage_second[4] = vsel_one_q[`RCR_VSEL_LIN_THREE];
	assign core_voltage_second = {vsel_one_q[`RCR_VSEL_CORE_TWO], vsel_one_q[`RCR_VSEL_CORE_ONE]};
	assign peripheral_switch_closed = ctrl_q[3][`RCR_BIT_PERI_SWITCH];

	// ==================================================================
	// Assertions.
	// ==================================================================
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_ON_RISE: assert property (on_rise[0] |=> regulator_on[0])
		else $error("Enable pin rise did not switch the regulator on.");
	AST_ON_FALL: assert property (on_fall[0] |=> !regulator_on[0])
		else $error("Enable pin fall did not switch the regulator off.");
	AST_SEQ_BUCK: assert property (seq_hit[0] |=> regulator_on[0] == $past(ctrl_q[0][3]))
		else $error("Buck did not take its sequencer target.");
	AST_SEQ_LIN: assert property (seq_hit[4] |=> regulator_on[4] == $past(ctrl_q[4][7]))
		else $error("Linear regulator did not take its sequencer target.");
	AST_MEM_GATE: assert property (seq.step && !memory_default_supply && !wr_fire
		&& ctrl_q[1][2:1] == 2'b00 |=> $stable(regulator_on[1]))
		else $error("Memory buck moved without default supply.");
	AST_VOLT_PIN: assert property (v_fall[0] |=> voltage_second[0] ##1 $stable(voltage_second[0])
		|| $past(v_rise[0]))
		else $error("Falling voltage pin did not select target B.");
	AST_LIN_IMM: assert property (v_rise[5] |=> !voltage_second[5])
		else $error("Linear voltage did not change at once.");
	// The registered outputs hold their reset value for one edge after release.
	AST_PULLDOWN: assert property ($past(presetn)
		|-> pulldown_on[1] == (!regulator_on[5] && !ctrl_q[5][3]))
		else $error("Pull-down state disagrees with enable and disable bit.");
	AST_VIB_BRAKE: assert property (($past(presetn) && vib_q[5:0] == 6'h00) [*2]
		|-> vib_low_side && !vib_high_side)
		else $error("Zero vibration level did not brake.");
	AST_VIB_FULL: assert property ((vib_q[5:0] == 6'h3f) [*2] |-> vib_high_side)
		else $error("Full vibration level did not drive high.");
	AST_RSVD: assert property (wr_fire && hit_ctrl[0] |=> ctrl_q[0][7] == 1'b0 && ctrl_q[0][4] == 1'b0)
		else $error("Reserved bits stored a written value.");
	AST_APB_READY: assert property (setup |=> pready ##1 !pready)
		else $error("APB answer was not a single ready cycle.");

	COV_PIN_ON: cover property (on_rise[3] ##1 regulator_on[3]);
	COV_SEQ_ON: cover property (seq_hit[4] && ctrl_q[4][7]);
	COV_VIB_RUN: cover property (vib_high_side ##1 vib_low_side);
	COV_ERR: cover property (pready && pslverr);

endmodule // rcr_bank

//--- bench/rcr_pin_model.sv
// Far-side model that drives the general pins and the sequencer slot strobe.
`timescale 1ns/1ps
module rcr_pin_model
	import rcr_pkg::*;
(
	// Clock.
	input wire logic pclk,
	// Pin and sequencer drive.
	output rcr_pins_t pins,
	output rcr_seq_t seq
);
	// ==================================================================
	// Drive tasks, each changing its signals just after a rising edge.
	// ==================================================================
	initial
	begin
		pins = '0;
		seq = '0;
	end

	// Moves one pin, bit 0 pin one to bit 2 pin thirteen, to a new level.
	task automatic set_pin(input int unsigned which, input logic level);
	begin
		@(posedge pclk);
		pins[which] <= level;
	end
	endtask

	// Announces one slot with a single-cycle strobe.
	task automatic step(input logic [3:0] slot);
	begin
		@(posedge pclk);
		seq <= {1'b1, slot};
		@(posedge pclk);
		seq <= '0;
	end
	endtask
endmodule // rcr_pin_model

//--- bench/rcr_bank_test.sv
// Self-checking bench for the regulator control bank.
`timescale 1ns/1ps
module rcr_bank_test
	import rcr_pkg::*;
();
	// ==================================================================
	// Signals, counters and the register table.
	// ==================================================================
	logic pclk = 1'b0; // Bench clock, 20 ns period.
	logic presetn = 1'b0; // Reset, active low.
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hf; // Byte lane 0 always enabled.
	logic mem_default = 1'b0; // Memory buck default supply level.
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	rcr_pins_t pins;
	rcr_seq_t seq;
	logic [8:0] regulator_on;
	logic [8:0] voltage_second;
	logic [1:0] core_voltage_second;
	logic [4:0] pulldown_on;
	logic peripheral_switch_closed;
	logic vib_high_side;
	logic vib_low_side;
	int error_cnt = 0; // Mismatches seen.
	int checks_done = 0; // Comparisons made.
	int hi_cnt;
	int lo_cnt;
	// Every mapped index, reserved 0x26, 0x29 and 0x2f, and the bits that read back after all ones.
	logic [7:0] idx_tab [20] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h28, 8'h29,
		8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h31, 8'h32, 8'h33, 8'h40, 8'h41, 8'h42,
		8'h43, 8'h44};
	logic [7:0] mask_tab [20] = '{8'h6f, 8'h6f, 8'h6f, 8'hff, 8'h00, 8'hef, 8'h00,
		8'hff, 8'hff, 8'hff, 8'h00, 8'hff, 8'h3f, 8'h9f, 8'h01, 8'hff, 8'hff, 8'hff,
		8'hff, 8'h0f};

	always #10 pclk = ~pclk;

	rcr_pin_model u_far (.pclk(pclk), .pins(pins), .seq(seq));

	rcr_bank u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pins(pins), .seq(seq),
		.memory_default_supply(mem_default), .regulator_on(regulator_on),
		.voltage_second(voltage_second), .core_voltage_second(core_voltage_second),
		.pulldown_on(pulldown_on), .peripheral_switch_closed(peripheral_switch_closed),
		.vib_high_side(vib_high_side), .vib_low_side(vib_low_side));

	// ==================================================================
	// Shared tasks.
	// ==================================================================
	// Prints the counts and the verdict, then ends the run.
	task automatic final_report;
	begin
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
	begin
		checks_done++;
		if (got !== exp)
		begin
			$display("FAIL %s expected %h seen %h", name, exp, got);
			error_cnt++;
		end
	end
	endtask

	// One APB transfer; the request stands until pready is sampled high.
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
	begin
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			$display("FAIL pready expected 1 seen timeout");
			error_cnt++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask

	// Writes one register.
	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		logic [31:0] rd;
		logic err;
	begin
		apb(1'b1, idx, wd, rd, err);
	end
	endtask

	// Reads one register and checks data and error flag.
	task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input logic eerr);
		logic [31:0] rd;
		logic err;
	begin
		apb(1'b0, idx, 32'h0000_0000, rd, err);
		chk("prdata", exp, rd);
		chk("pslverr", {31'b0, eerr}, {31'b0, err});
	end
	endtask

	// Lets n edges pass and steps off the edge.
	task automatic cyc(input int n);
	begin
		repeat (n) @(posedge pclk);
		#1;
	end
	endtask

	// ==================================================================
	// Test sequence.
	// ==================================================================
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		cyc(2);
		chk("pulldown_on", 32'h0000_001f, {27'b0, pulldown_on});
		chk("vib_low_side", 32'h0000_0001, {31'b0, vib_low_side});
		for (int i = 0; i < 20; i++)
			rd_chk(idx_tab[i], 32'h0000_0000, 1'b0);
		$display("test reset done");
		// All ones everywhere, then the readback masks and decoded outputs.
		for (int i = 0; i < 20; i++)
			wr(idx_tab[i], 32'h0000_00ff);
		for (int i = 0; i < 20; i++)
			rd_chk(idx_tab[i], {24'h0, mask_tab[i]}, 1'b0);
		cyc(2);
		chk("regulator_on", 32'h0000_01ff, {23'b0, regulator_on});
		chk("voltage_second", 32'h0000_01ff, {23'b0, voltage_second});
		chk("core_voltage", 32'h0000_0003, {30'b0, core_voltage_second});
		chk("switch", 32'h0000_0001, {31'b0, peripheral_switch_closed});
		chk("pulldown_on", 32'h0000_0000, {27'b0, pulldown_on});
		for (int i = 0; i < 20; i++)
			wr(idx_tab[i], 32'h0000_0000);
		rd_chk(8'h20, 32'h0000_0000, 1'b1);
		rd_chk(8'h45, 32'h0000_0000, 1'b1);
		$display("test registers done");
		// Each pin source enables and disables the processor buck.
		for (int c = 1; c < 4; c++)
		begin
			wr(8'h22, 32'(c << 1));
			u_far.set_pin(c - 1, 1'b1);
			cyc(3);
			chk("pin_on", 32'h0000_0001, {31'b0, regulator_on[0]});
			rd_chk(8'h22, 32'(c << 1) | 32'h0000_0001, 1'b0);
			u_far.set_pin(c - 1, 1'b0);
			cyc(3);
			chk("pin_off", 32'h0000_0000, {31'b0, regulator_on[0]});
		end
		wr(8'h22, 32'h0000_0000);
		u_far.set_pin(0, 1'b1);
		cyc(3);
		chk("pin_ignored", 32'h0000_0000, {31'b0, regulator_on[0]});
		u_far.set_pin(0, 1'b0);
		$display("test pin enable done");
		// Pin-driven voltage choice on a buck and on linear seven, both starting at B.
		wr(8'h32, 32'h0000_0004);
		wr(8'h22, 32'h0000_0020);
		wr(8'h2c, 32'h0000_0050);
		u_far.set_pin(0, 1'b1);
		u_far.set_pin(1, 1'b1);
		cyc(3);
		chk("volt_rise", 32'h0000_0000, {30'b0, voltage_second[5], voltage_second[0]});
		u_far.set_pin(0, 1'b0);
		u_far.set_pin(1, 1'b0);
		cyc(3);
		chk("volt_fall", 32'h0000_0003, {30'b0, voltage_second[5], voltage_second[0]});
		rd_chk(8'h32, 32'h0000_0004, 1'b0);
		rd_chk(8'h2c, 32'h0000_0050, 1'b0);
		$display("test pin voltage done");
		// Sequencer slots; the memory buck waits for the default supply level.
		wr(8'h22, 32'h0000_0008);
		wr(8'h2c, 32'h0000_0000);
		wr(8'h23, 32'h0000_0008);
		wr(8'h28, 32'h0000_0080);
		wr(8'h40, 32'h0000_0053);
		wr(8'h42, 32'h0000_0005);
		u_far.step(4'h5);
		cyc(3);
		chk("seq_gated", 32'h0000_0004, {29'b0, regulator_on[4], regulator_on[1:0]});
		u_far.step(4'h3);
		cyc(3);
		chk("seq_pro", 32'h0000_0005, {29'b0, regulator_on[4], regulator_on[1:0]});
		@(posedge pclk);
		mem_default <= 1'b1;
		u_far.step(4'h5);
		cyc(3);
		chk("seq_mem", 32'h0000_0007, {29'b0, regulator_on[4], regulator_on[1:0]});
		rd_chk(8'h23, 32'h0000_0009, 1'b0);
		$display("test sequencer done");
		// Pull-down disable, voltage choice and switch by register.
		wr(8'h2c, 32'h0000_0018);
		wr(8'h25, 32'h0000_0010);
		cyc(2);
		chk("pulldown_on", 32'h0000_001c, {27'b0, pulldown_on});
		chk("lin7_volt", 32'h0000_0001, {31'b0, voltage_second[5]});
		chk("switch", 32'h0000_0001, {31'b0, peripheral_switch_closed});
		$display("test direct controls done");
		// Motor levels: high cycles per 63-clock period equal the level.
		for (int v = 0; v < 64; v += 21)
		begin
			wr(8'h31, 32'(v));
			cyc(64);
			hi_cnt = 0;
			lo_cnt = 0;
			repeat (63)
			begin
				@(negedge pclk);
				hi_cnt += int'(vib_high_side === 1'b1);
				lo_cnt += int'(vib_low_side === 1'b1);
			end
			chk("vib_high", 32'(v), 32'(hi_cnt));
			if (v == 0)
				chk("vib_low", 32'h0000_003f, 32'(lo_cnt));
		end
		$display("test vibration done");
		final_report();
	end
endmodule // rcr_bank_test
